// File: hw/rws_pkg.sv
// reset, watchdog and sleep unit: shared constants and carriers
// assumes a single 25 MHz system clock; oscillators modelled as enable ticks
package rws_pkg;

   // =========================================================
   // timing
   localparam int          CLK_PERIOD_NS   = 40;
   localparam int          DRT_LONG_US     = 18000;
   localparam int          DRT_SHORT_US    = 300;
   localparam int          WDT_BASE_US     = 18000;
   localparam int          DRT_LONG_CYC    = (DRT_LONG_US * 1000) / CLK_PERIOD_NS;
   localparam int          DRT_SHORT_CYC   = (DRT_SHORT_US * 1000) / CLK_PERIOD_NS;
   localparam int          WDT_BASE_CYC    = (WDT_BASE_US * 1000) / CLK_PERIOD_NS;
   localparam int          CNT_W           = 24;

   // =========================================================
   // register map (register port addresses)
   localparam logic [2:0]  ADDR_OPTIONS    = 3'h0;
   localparam logic [2:0]  ADDR_STATUS     = 3'h1;
   localparam logic [2:0]  ADDR_CTRL       = 3'h2;
   localparam logic [7:0]  OPTIONS_RESET   = 8'hFF;

   // options fields
   localparam int          OPT_WAKE_N      = 7;
   localparam int          OPT_PULLUP_N    = 6;
   localparam int          OPT_TCS         = 5;
   localparam int          OPT_TSE         = 4;
   localparam int          OPT_PSA         = 3;
   localparam int          OPT_PS_LO       = 0;

   // status fields
   localparam int          ST_WAKE_FLAG    = 7;
   localparam int          ST_TO_N         = 4;
   localparam int          ST_PD_N         = 3;

   // control register bits (write 1 to act)
   localparam int          CTRL_WATCHDOG_CLEAR_INSTR     = 0;
   localparam int          CTRL_SLEEP      = 1;
   localparam int          CTRL_PORT_SNAP  = 2;

   // oscillator modes
   typedef enum logic [2:0] {
      RWS_OSC_INT_RC, RWS_OSC_EXT_RC, RWS_OSC_HS, RWS_OSC_XT, RWS_OSC_LP
   } rws_osc_t;

   // cause-of-reset flags
   typedef struct packed {
      logic wake_flag;
      logic timeout_n;
      logic powerdown_n;
   } rws_cause_t;

   // configuration fuses
   typedef struct packed {
      logic     wdt_en;
      logic     master_clear_pin_n_en;
      rws_osc_t osc_mode;
   } rws_fuse_t;

endpackage : rws_pkg

// File: hw/rws_unit.sv
// reset, watchdog and sleep control unit for a small microcontroller core
// assumes fuses are static; pins are asynchronous; register port is on clk_sys
`timescale 1ns/1ps
`default_nettype none

module rws_unit
   import rws_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire rws_fuse_t  fuse,
   input  wire logic       master_clear_pin_n,
   input  wire logic [3:0] port_pins,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   output logic            core_reset,
   output logic            core_resume,
   output logic            osc_drive_en,
   output logic            port_hold,
   output logic            master_clear_pin_n_pin_oe,
   output logic [7:0]      options_out
);

   // =========================================================
   // pin synchronisers
   logic [1:0] master_clear_pin_n_sync_r;
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         master_clear_pin_n_sync_r <= 2'h0;
         pin_s1_r    <= 4'h0;
         pin_s2_r    <= 4'h0;
      end else begin
         master_clear_pin_n_sync_r <= {master_clear_pin_n_sync_r[0], master_clear_pin_n};
         pin_s1_r    <= port_pins;
         pin_s2_r    <= pin_s1_r;
      end
   end

   logic master_clear_pin_n_low;
   assign master_clear_pin_n_low = fuse.master_clear_pin_n_en & ~master_clear_pin_n_sync_r[1];

   function automatic logic is_rc(input rws_osc_t m);
      return (m == RWS_OSC_INT_RC) || (m == RWS_OSC_EXT_RC);
   endfunction : is_rc

   function automatic logic [CNT_W-1:0] delay_len(input logic por, input rws_osc_t m);
      if (!por && is_rc(m))
         return CNT_W'(DRT_SHORT_CYC);
      return CNT_W'(DRT_LONG_CYC);
   endfunction : delay_len

   // =========================================================
   // state
   typedef enum logic [1:0] {RWS_HOLD, RWS_RUN, RWS_SLEEP} rws_state_t;

   rws_state_t          state_r, state_nxt;
   logic [CNT_W-1:0]    drt_r, drt_nxt;
   logic                drt_por_r, drt_por_nxt;
   logic [CNT_W-1:0]    wdt_r, wdt_nxt;
   logic [7:0]          pre_r, pre_nxt;
   logic [7:0]          opt_r, opt_nxt;
   rws_cause_t          cause_r, cause_nxt;
   logic [3:0]          snap_r, snap_nxt;
   logic                resume_r, resume_nxt;
   logic [7:0]          rdata_nxt;

   logic       wr_opt, wr_ctrl, watchdog_clear_instr, sleep_cmd, snap_cmd;
   logic       wdt_tick, wdt_timeout, pin_change;
   logic [7:0] pre_limit;

   assign wr_opt    = reg_wr && (reg_addr == ADDR_OPTIONS);
   assign wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL) && (state_r == RWS_RUN);
   assign watchdog_clear_instr    = wr_ctrl && reg_wdata[CTRL_WATCHDOG_CLEAR_INSTR];
   assign sleep_cmd = wr_ctrl && reg_wdata[CTRL_SLEEP];
   assign snap_cmd  = wr_ctrl && reg_wdata[CTRL_PORT_SNAP];
   assign pre_limit = opt_r[OPT_PSA] ? 8'((9'h1 << opt_r[OPT_PS_LO +: 3]) - 9'h1) : 8'h00;
   assign wdt_tick  = (pre_r >= pre_limit);
   // watchdog counts in every state, on its own path independent of core clock
   assign wdt_timeout = fuse.wdt_en && wdt_tick && (wdt_r >= CNT_W'(WDT_BASE_CYC - 1));
   assign pin_change  = !opt_r[OPT_WAKE_N] && (pin_s2_r != snap_r);

   always_comb begin
      state_nxt   = state_r;
      drt_nxt     = drt_r;
      drt_por_nxt = drt_por_r;
      opt_nxt     = opt_r;
      cause_nxt   = cause_r;
      snap_nxt    = snap_cmd ? pin_s2_r : snap_r;
      resume_nxt  = resume_r;
      // watchdog and prescaler
      if (!fuse.wdt_en) begin
         wdt_nxt = '0;
         pre_nxt = 8'h00;
      end else if (wdt_tick) begin
         pre_nxt = 8'h00;
         wdt_nxt = wdt_timeout ? '0 : wdt_r + CNT_W'(1);
      end else begin
         pre_nxt = pre_r + 8'h01;
         wdt_nxt = wdt_r;
      end
      if (watchdog_clear_instr || sleep_cmd) begin
         wdt_nxt = '0;
         if (opt_r[OPT_PSA])
            pre_nxt = 8'h00;
      end
      if (wr_opt)
         opt_nxt = reg_wdata;

      unique case (state_r)
         RWS_HOLD: begin
            // power-on count waits for clear pin high
            if (master_clear_pin_n_low) begin
               drt_nxt = delay_len(drt_por_r, fuse.osc_mode);
            end else if (drt_r != '0) begin
               drt_nxt = drt_r - CNT_W'(1);
            end else begin
               state_nxt   = RWS_RUN;
               drt_por_nxt = 1'b0;
            end
            if (wdt_timeout) begin
               drt_nxt = delay_len(drt_por_r, fuse.osc_mode);
            end
         end
         RWS_RUN: begin
            if (wdt_timeout) begin
               state_nxt          = RWS_HOLD;
               drt_nxt            = delay_len(1'b0, fuse.osc_mode);
               cause_nxt.timeout_n = 1'b0;
               cause_nxt.wake_flag = 1'b0;
               resume_nxt         = 1'b0;
               opt_nxt            = OPTIONS_RESET;
            end else if (master_clear_pin_n_low) begin
               state_nxt          = RWS_HOLD;
               drt_nxt            = delay_len(1'b0, fuse.osc_mode);
               cause_nxt.wake_flag = 1'b0;
               resume_nxt         = 1'b0;
               opt_nxt            = OPTIONS_RESET;
            end else if (sleep_cmd) begin
               state_nxt            = RWS_SLEEP;
               cause_nxt.timeout_n   = 1'b1;
               cause_nxt.powerdown_n = 1'b0;
            end
         end
         RWS_SLEEP: begin
            if (wdt_timeout || master_clear_pin_n_low || pin_change) begin
               state_nxt             = RWS_HOLD;
               drt_nxt               = delay_len(1'b0, fuse.osc_mode);
               wdt_nxt               = '0;
               pre_nxt               = opt_r[OPT_PSA] ? 8'h00 : pre_nxt;
               cause_nxt.powerdown_n = 1'b0;
               opt_nxt               = OPTIONS_RESET;
               if (wdt_timeout) begin
                  cause_nxt = '{wake_flag: 1'b0, timeout_n: 1'b0, powerdown_n: 1'b0};
                  resume_nxt = 1'b1;
               end else if (master_clear_pin_n_low) begin
                  cause_nxt = '{wake_flag: 1'b0, timeout_n: 1'b1, powerdown_n: 1'b0};
                  resume_nxt = 1'b1;
               end else begin
                  cause_nxt = '{wake_flag: 1'b1, timeout_n: 1'b1, powerdown_n: 1'b0};
                  resume_nxt = 1'b0;
               end
            end
         end
      endcase
   end

   // register read port
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_STATUS: begin
               rdata_nxt[ST_WAKE_FLAG] = cause_r.wake_flag;
               rdata_nxt[ST_TO_N]      = cause_r.timeout_n;
               rdata_nxt[ST_PD_N]      = cause_r.powerdown_n;
            end
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // =========================================================
   // registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r      <= RWS_HOLD;
         drt_r        <= CNT_W'(DRT_LONG_CYC);
         drt_por_r    <= 1'b1;
         wdt_r        <= '0;
         pre_r        <= 8'h00;
         opt_r        <= OPTIONS_RESET;
         cause_r      <= '{wake_flag: 1'b0, timeout_n: 1'b1, powerdown_n: 1'b1};
         snap_r       <= 4'h0;
         resume_r     <= 1'b0;
         reg_rdata    <= 8'h00;
         core_reset   <= 1'b1;
         core_resume  <= 1'b0;
         osc_drive_en <= 1'b1;
         port_hold    <= 1'b0;
         options_out  <= OPTIONS_RESET;
         master_clear_pin_n_pin_oe  <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         drt_r        <= drt_nxt;
         drt_por_r    <= drt_por_nxt;
         wdt_r        <= wdt_nxt;
         pre_r        <= pre_nxt;
         opt_r        <= opt_nxt;
         cause_r      <= cause_nxt;
         snap_r       <= snap_nxt;
         resume_r     <= resume_nxt;
         reg_rdata    <= rdata_nxt;
         core_reset   <= (state_nxt == RWS_HOLD);
         core_resume  <= resume_nxt;
         osc_drive_en <= (state_nxt != RWS_SLEEP);
         port_hold    <= (state_nxt == RWS_SLEEP);
         options_out  <= opt_nxt;
         master_clear_pin_n_pin_oe  <= 1'b0;
      end
   end

endmodule : rws_unit

`default_nettype wire

// File: sim/rws_unit_properties.sv
// port checker for the reset, watchdog and sleep unit
// assumes one clock clk_sys and the async active-low reset rst_n
`timescale 1ns/1ps
`default_nettype none
module rws_unit_properties
   import rws_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       core_reset,
   input wire logic       osc_drive_en,
   input wire logic       port_hold,
   input wire logic       master_clear_pin_n_pin_oe,
   input wire logic [7:0] options_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // assertions
   oe_never_a:
      assert property (master_clear_pin_n_pin_oe == 1'b0) else $error("clear pin driven");
   sleep_entry_a:
      assert property (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_SLEEP] && !core_reset && osc_drive_en
         |=> !osc_drive_en && port_hold) else $error("sleep not entered");
   sleep_hold_a:
      assert property (!osc_drive_en |-> port_hold) else $error("pins not held in sleep");
   opt_write_a:
      assert property (reg_wr && reg_addr == ADDR_OPTIONS && !core_reset |=> options_out == $past(reg_wdata))
         else $error("options write lost");
   opt_read_a:
      assert property (reg_rd && reg_addr == ADDR_OPTIONS |=> reg_rdata == 8'h00) else $error("options readable");
   reset_min_a:
      assert property ($rose(core_reset) |-> core_reset [*8]) else $error("reset too short");
   ctl_refused_a:
      assert property (core_reset && reg_wr && reg_addr == ADDR_CTRL |=> $stable(osc_drive_en))
         else $error("control taken in reset");
   asleep_flags_a:
      assert property (reg_rd && reg_addr == ADDR_STATUS && !osc_drive_en && !core_reset
         |=> reg_rdata[ST_TO_N] && !reg_rdata[ST_PD_N]) else $error("sleep flags wrong");
   cov_sleep: cover property (!osc_drive_en);
   cov_rise: cover property ($rose(core_reset));
   cov_fall: cover property ($fell(core_reset));
endmodule : rws_unit_properties
bind rws_unit rws_unit_properties i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset(core_reset),
   .osc_drive_en(osc_drive_en), .port_hold(port_hold), .master_clear_pin_n_pin_oe(master_clear_pin_n_pin_oe), .options_out(options_out));
`default_nettype wire

// File: sim/rws_far_end.sv
// far side: clear pin with pull-up and the four wake-capable port pins
// assumes the bench commands each change; pins move just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module rws_far_end (
   input  wire logic       clk_sys,
   input  wire logic       clear_req,
   input  wire logic [3:0] pin_req,
   output logic            master_clear_pin_n,
   output logic [3:0]      port_pins
);
   // released pin rises through its pull-up
   always @(posedge clk_sys) begin
      master_clear_pin_n <= !clear_req;
      port_pins <= pin_req;
   end
endmodule : rws_far_end
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the reset, watchdog and sleep unit
// assumes the checker binds itself; watchdog fuse held off, internal RC mode
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import rws_pkg::*;
   ;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   rws_fuse_t  fuse = '{1'b0, 1'b1, RWS_OSC_INT_RC};
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       clear_req = 1'b1;
   logic [3:0] pin_req = 4'h0;
   logic [7:0] reg_rdata, options_out, v;
   logic       core_reset, core_resume, osc_drive_en, port_hold, master_clear_pin_n_pin_oe, master_clear_pin_n;
   logic [3:0] port_pins;
   int         errors = 0;
   int         n_tests = 0;
   int         seed = 47;
   int         n;
   int         st_m;
   always #20 clk_sys = ~clk_sys;
   rws_unit i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .fuse(fuse), .master_clear_pin_n(master_clear_pin_n),
      .port_pins(port_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .core_reset(core_reset), .core_resume(core_resume), .osc_drive_en(osc_drive_en),
      .port_hold(port_hold), .master_clear_pin_n_pin_oe(master_clear_pin_n_pin_oe), .options_out(options_out));
   rws_far_end i_far (.clk_sys(clk_sys), .clear_req(clear_req), .pin_req(pin_req),
      .master_clear_pin_n(master_clear_pin_n), .port_pins(port_pins));
   // ==========================================
   // tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // waits for the hold to start, then measures it
   task automatic reset_delay_timer(input int len);
      for (int i = 0; i < 10 && core_reset !== 1'b1; i++) @(negedge clk_sys);
      n = 0;
      while (core_reset !== 1'b0 && n < len + 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk({7'h0, n >= len && n <= len + 10}, 8'h01, "delay length");
   endtask : reset_delay_timer
   task automatic nap();
      wr(ADDR_CTRL, 8'h04);
      wr(ADDR_CTRL, 8'h02);
      st_m = (st_m | 8'h10) & 8'h97;
   endtask : nap
   task automatic pulse_clear();
      @(posedge clk_sys);
      clear_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      clear_req <= 1'b0;
   endtask : pulse_clear
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   // ==========================================
   // sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      st_m = 8'h18;
      rd(ADDR_STATUS, v);
      chk(v, st_m[7:0], "power-up status");
      chk(options_out, OPTIONS_RESET, "options reset");
      wr(ADDR_CTRL, 8'h02);
      repeat (20) @(negedge clk_sys);
      chk({6'h0, osc_drive_en, core_reset}, 8'h03, "held while pin low");
      @(posedge clk_sys);
      clear_req <= 1'b0;
      reset_delay_timer(DRT_LONG_CYC);
      $display("test power-on done");
      repeat (4) begin
         v = 8'($random(seed));
         wr(ADDR_OPTIONS, v);
         @(negedge clk_sys);
         chk(options_out, v, "options write");
      end
      rd(ADDR_OPTIONS, v);
      chk(v, 8'h00, "options read");
      rd(3'h5, v);
      chk(v, 8'h00, "unmapped read");
      $display("test registers done");
      wr(ADDR_OPTIONS, 8'h7F);
      nap();
      rd(ADDR_STATUS, v);
      chk(v, st_m[7:0], "sleep status");
      chk({6'h0, osc_drive_en, port_hold}, 8'h01, "sleep outputs");
      @(posedge clk_sys);
      pin_req <= 4'h1 << ($random(seed) & 3);
      reset_delay_timer(DRT_SHORT_CYC);
      st_m = st_m | 8'h80;
      rd(ADDR_STATUS, v);
      chk(v, st_m[7:0], "pin wake status");
      chk({6'h0, core_resume, options_out == OPTIONS_RESET}, 8'h01, "pin wake");
      $display("test pin wake done");
      nap();
      pulse_clear();
      reset_delay_timer(DRT_SHORT_CYC);
      st_m = 8'h10;
      rd(ADDR_STATUS, v);
      chk(v, st_m[7:0], "clear wake status");
      chk({7'h0, core_resume}, 8'h01, "resumption");
      @(posedge clk_sys);
      pin_req <= ~pin_req;
      repeat (10) @(negedge clk_sys);
      chk({7'h0, core_reset}, 8'h00, "change while running");
      pulse_clear();
      reset_delay_timer(DRT_SHORT_CYC);
      rd(ADDR_STATUS, v);
      chk(v, st_m[7:0], "clear while running");
      $display("test clear pin done");
      end_of_test();
   end
   initial begin
      #22400000;
      errors++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
